/* bench/sms_cpu_model.sv */
`timescale 1ns/1ps
module sms_cpu_model (
   input  wire logic         mclk_i,
   input  wire logic         mem_access_i,
   output sms_pkg::sms_irq_t irq_o,
   output logic              stop_exec_o,
   output logic              reset_pin_n_o,
   output logic              wake_pin_n_o,
   output logic              background_o,
   output logic              mem_status_o
);
   initial begin
      irq_o = '0;
      stop_exec_o = 1'b0;
      reset_pin_n_o = 1'b1;
      wake_pin_n_o = 1'b1;
      background_o = 1'b0;
      mem_status_o = 1'b0;
   end
   // the stop instruction lasts exactly one bus cycle
   task automatic stop_insn();
      @(posedge mclk_i);
      stop_exec_o <= 1'b1;
      @(posedge mclk_i);
      stop_exec_o <= 1'b0;
   endtask
   task automatic bg_cmd();
      @(posedge mclk_i);
      background_o <= 1'b1;
      @(posedge mclk_i);
      background_o <= 1'b0;
   endtask
   // access strobe is looked at while the command is still up
   task automatic mem_cmd(output logic acc);
      @(posedge mclk_i);
      mem_status_o <= 1'b1;
      @(negedge mclk_i);
      acc = mem_access_i;
      @(posedge mclk_i);
      mem_status_o <= 1'b0;
   endtask
   task automatic drive(input sms_pkg::sms_irq_t irq, input logic rst_n, input logic wake_n);
      @(posedge mclk_i);
      irq_o <= irq;
      reset_pin_n_o <= rst_n;
      wake_pin_n_o <= wake_n;
   endtask
endmodule // sms_cpu_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
`include "sms_defs.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", n, e, a); end end
`define WT(s, n) begin for (int k = 0; k < 8; k++) begin @(negedge mclk_i); \
   if ((s) === 1'b1) break; end `CHK(n, 1'b1, s) if ((s) !== 1'b1) final_report(); end
module tb_top;
   localparam logic [1:0] M_RUN = 2'h0;
   localparam logic [1:0] M_S3  = 2'h1;
   localparam logic [1:0] M_S2  = 2'h3;
   localparam logic [1:0] M_S1  = 2'h2;
   logic                  mclk_i = 1'b0;
   logic                  rst_n_i = 1'b0;
   sms_pkg::sms_axi_m2s_t axi = '0;
   sms_pkg::sms_axi_s2m_t axo;
   sms_pkg::sms_irq_t     irq, isrc;
   logic [1:0]            mode;
   logic                  stx, rpn, wpn, bgc, mst, macc, bus_en, cpu_en, per_en, bdm_en;
   logic                  rfull, ron, corep, ramp, adcr, irefr, xoscr, latch, hiz, wkm;
   logic                  wkpu, ill, sysr, por, irqv, bdme, bstop, partial_power_down_flag, deep_power_down_flag, acc;
   int                    num_errors = 0;
   int                    cmp_count = 0;
   always #12.5 mclk_i = ~mclk_i;
   sms_stop_sequencer u_dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .stop_exec_i(stx), .reset_pin_n_i(rpn),
      .wake_pin_n_i(wpn), .irq_i(irq), .bdc_background_i(bgc), .bdc_mem_status_i(mst),
      .axi_i(axi), .axi_o(axo), .stop_mode_o(mode), .bus_clk_en_o(bus_en),
      .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .bdm_clk_en_o(bdm_en),
      .regulator_full_o(rfull), .regulator_on_o(ron), .core_power_o(corep),
      .ram_power_o(ramp), .adc_run_o(adcr), .int_ref_run_o(irefr), .ext_osc_run_o(xoscr),
      .pin_latch_o(latch), .pin_hiz_o(hiz), .wake_pin_mode_o(wkm),
      .wake_pin_pullup_en_o(wkpu), .illegal_op_reset_o(ill), .sys_reset_o(sysr),
      .por_reset_o(por), .irq_vector_o(irqv), .irq_src_o(isrc), .bdm_enter_o(bdme),
      .bdc_mem_access_o(macc), .bdc_stop_err_o(bstop), .partial_power_down_flag_o(partial_power_down_flag), .pdf_o(deep_power_down_flag));
   sms_cpu_model u_cpu (
      .mclk_i(mclk_i), .mem_access_i(macc), .irq_o(irq), .stop_exec_o(stx),
      .reset_pin_n_o(rpn), .wake_pin_n_o(wpn), .background_o(bgc), .mem_status_o(mst));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic tmo(input string nm);
      num_errors++;
      $display("BAD %s exp handshake got timeout", nm);
      final_report();
   endtask
   // valid signals are looked at on the falling edge, the transfer happens on the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      int   n;
      @(posedge mclk_i);
      axi.awvalid <= 1'b1;
      axi.awaddr <= a;
      axi.wvalid <= 1'b1;
      axi.wdata <= d;
      axi.wstrb <= 4'hF;
      axi.bready <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      for (n = 0; n < 40 && !(ta && tw); n++) begin
         @(negedge mclk_i);
         if (axi.awvalid && axo.awready === 1'b1) ta = 1'b1;
         if (axi.wvalid && axo.wready === 1'b1) tw = 1'b1;
         @(posedge mclk_i);
         if (ta) axi.awvalid <= 1'b0;
         if (tw) axi.wvalid <= 1'b0;
      end
      if (!(ta && tw)) tmo("aw_w");
      for (n = 0; n < 40; n++) begin
         @(negedge mclk_i);
         if (axo.bvalid === 1'b1) break;
      end
      if (n == 40) tmo("bvalid");
      r = axo.bresp;
      @(posedge mclk_i);
      axi.bready <= 1'b0;
      @(negedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk_i);
      axi.arvalid <= 1'b1;
      axi.araddr <= a;
      axi.rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk_i);
         if (axo.arready === 1'b1) break;
      end
      if (n == 40) tmo("arready");
      @(posedge mclk_i);
      axi.arvalid <= 1'b0;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk_i);
         if (axo.rvalid === 1'b1) break;
      end
      if (n == 40) tmo("rvalid");
      d = axo.rdata;
      r = axo.rresp;
      @(posedge mclk_i);
      axi.rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      `CHK("rd_resp", `SMS_RESP_OKAY, r)
      `CHK("rd_data", e, d)
   endtask
   task automatic enter(input logic [31:0] v);
      logic [1:0] r;
      wr(`SMS_OFS_CFG, v, r);
      u_cpu.stop_insn();
      @(negedge mclk_i);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rchk(`SMS_OFS_CFG, 32'h0000_0000);
      rchk(`SMS_OFS_STAT, 32'h0000_0000);
      wr(`SMS_OFS_CFG, 32'hFFFF_FFFF, r);
      rchk(`SMS_OFS_CFG, 32'h0000_3FFF);
      `CHK("pullup", 1'b1, wkpu)
      wr(8'h08, 32'h0000_0000, r);
      `CHK("wr_resp", `SMS_RESP_SLVERR, r)
      rd(8'h08, d, r);
      `CHK("rd_resp", `SMS_RESP_SLVERR, r)
      `CHK("rd_data", 32'h0000_0000, d)
      rchk(`SMS_OFS_CFG, 32'h0000_3FFF);
   endtask
   task automatic t_illegal();
      enter(32'h0000_001E);
      `CHK("ill", 1'b1, ill)
      `CHK("mode", M_RUN, mode)
      @(negedge mclk_i);
      `CHK("ill", 1'b0, ill)
   endtask
   task automatic t_dbg();
      logic [1:0] r;
      enter(32'h0000_0013);
      `CHK("mode", M_S3, mode)
      `CHK("clk", 3'h0, {bus_en, cpu_en, per_en})
      `CHK("dbg", 2'h3, {bdm_en, rfull})
      wr(`SMS_OFS_CFG, 32'h0000_0011, r);
      `CHK("mode", M_S3, mode)
      u_cpu.mem_cmd(acc);
      `CHK("access", 1'b0, acc)
      @(negedge mclk_i);
      `CHK("stop_err", 1'b1, bstop)
      u_cpu.bg_cmd();
      `WT(bdme, "bdm_enter")
      `CHK("mode", M_RUN, mode)
   endtask
   task automatic t_lvd();
      for (int i = 0; i < 5; i++) begin
         enter(32'h0000_1F5D);
         `CHK("mode", M_S3, mode)
         `CHK("run", 2'h3, {rfull, corep})
         `CHK("run_opt", 3'h7, {adcr, irefr, xoscr})
         `CHK("held", 5'h02, {bdm_en, latch, hiz, ramp, 1'b0})
         u_cpu.drive(5'(1 << i), 1'b1, 1'b1);
         `WT(irqv, "irq_vec")
         `CHK("irq_src", 5'(1 << i), isrc)
         `CHK("mode", M_RUN, mode)
         u_cpu.drive('0, 1'b1, 1'b1);
      end
   endtask
   task automatic t_rst();
      enter(32'h0000_1D45);
      `CHK("mode", M_S3, mode)
      `CHK("stby", 4'h0, {rfull, adcr, irefr, xoscr})
      u_cpu.drive('0, 1'b0, 1'b1);
      `WT(sysr, "sys_reset")
      `CHK("mode", M_RUN, mode)
      u_cpu.drive('0, 1'b1, 1'b1);
   endtask
   task automatic t_stop2();
      logic [1:0] r;
      enter(32'h0000_0031);
      `CHK("mode", M_S2, mode)
      `CHK("pwr", 3'h5, {latch, corep, ramp})
      `CHK("wake_pin", 2'h2, {wkm, wkpu})
      u_cpu.drive('0, 1'b1, 1'b0);
      `WT(por, "por")
      `CHK("flags", 3'h6, {partial_power_down_flag, latch, deep_power_down_flag})
      rchk(`SMS_OFS_CFG, 32'h0000_0000);
      rchk(`SMS_OFS_STAT, 32'h0000_0011);
      u_cpu.drive('0, 1'b1, 1'b1);
      // software has put back ports and peripherals by now
      wr(`SMS_OFS_STAT, 32'h0000_0100, r);
      `CHK("ack", 2'h0, {partial_power_down_flag, latch})
   endtask
   task automatic t_stop1();
      logic [1:0] r;
      enter(32'h0000_0091);
      `CHK("mode", M_S1, mode)
      `CHK("off", 4'h8, {hiz, ramp, ron, corep})
      u_cpu.drive(5'h01, 1'b1, 1'b1);
      repeat (4) @(negedge mclk_i);
      `CHK("mode", M_S1, mode)
      u_cpu.drive(5'h10, 1'b1, 1'b1);
      `WT(por, "por")
      `CHK("flags", 2'h1, {partial_power_down_flag, deep_power_down_flag})
      u_cpu.drive('0, 1'b1, 1'b1);
      rchk(`SMS_OFS_STAT, 32'h0000_0002);
      wr(`SMS_OFS_STAT, 32'h0000_0100, r);
      `CHK("pdf", 1'b0, deep_power_down_flag)
   endtask
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_illegal();
      t_dbg();
      t_lvd();
      t_rst();
      t_stop2();
      t_stop1();
      final_report();
   end
endmodule // tb_top

/* verilog/sms_defs.svh */
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH
`define SMS_OFS_CFG      8'h00
`define SMS_OFS_STAT     8'h04
`define SMS_CFG_RST      14'h0000
`define SMS_ACK_BIT      8
`define SMS_RESP_OKAY    2'h0
`define SMS_RESP_SLVERR  2'h2
`endif

/* verilog/sms_pkg.sv */
package sms_pkg;
   // gray order along run -> stop3 -> stop2 -> stop1
   typedef enum logic [1:0] {
      SMS_RUN   = 2'h0,
      SMS_STOP3 = 2'h1,
      SMS_STOP2 = 2'h3,
      SMS_STOP1 = 2'h2
   } sms_mode_t;
   typedef struct packed {
      logic wake_pin_pullup_enable;
      logic osc_range_hi;
      logic external_ref_stop_enable;
      logic external_ref_clock_enable;
      logic internal_ref_stop_enable;
      logic internal_ref_clock_enable;
      logic rti_wake_en;
      logic adc_async_clk;
      logic partial_power_down_control;
      logic power_down_control;
      logic low_volt_detect_in_stop_enable;
      logic low_volt_detect_enable;
      logic debug_mode_enable;
      logic stop_enable_bit;
   } sms_cfg_t;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } sms_axi_m2s_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sms_axi_s2m_t;
   typedef struct packed {
      logic       periodic_wake_interrupt;
      logic       low_voltage_detector;
      logic       adc;
      logic       ext;
      logic       kbd;
   } sms_irq_t;
   typedef struct packed {
      sms_mode_t   mode;
      sms_cfg_t    cfg;
      logic        bdm_stop;
      logic        vreg_stop;
      logic        partial_power_down_flag;
      logic        deep_power_down_flag;
      logic        latch_hold;
      logic        rst_s1;
      logic        rst_s2;
      logic        wk_s1;
      logic        wk_s2;
      logic        sys_rst;
      logic        por;
      logic        irq_vec;
      sms_irq_t    irq_src;
      logic        bdm_enter;
      logic        ill_rst;
      logic        dbg_err;
      logic        aw_got;
      logic [7:0]  awaddr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sms_state_t;
endpackage

/* verilog/sms_stop_sequencer.sv */
// Notes on behaviour
// - stop disabled: illegal-opcode reset, no stop
// - debug enabled: stop3 with debug clocks
// - both detect bits: stop3, regulator active
// - otherwise power-down off: stop3
// - power-down and partial set: stop2
// - power-down, partial clear: stop1
// - any stop halts bus, cpu, peripheral clocks
// - stop3 keeps state, ram, pins
// - stop3 exits by reset pin, interrupts or, in debug stop, background
// - adc runs in stop3 only async+detect
// - debug stop keeps debug clocks, full regulation
// - stopped: status commands error; background wakes debug stop
// - stop2: power off except ram, latch pins
// - stop2/1 wake pin active low, pullup only if software enabled it
// - periodic interrupt wakes stop2/1 when enabled
// - stop2/1 wake behaves as power-on reset
// - stop2 wake sets flag, holds latches until ack
// - latch release hands pins to port control
// - stop1 powers off ram, pins high impedance
// - stop1 wake sets flag until ack
// - oscillator runs in stop3 only if enabled
`timescale 1ns/1ps
`include "sms_defs.svh"
module sms_stop_sequencer (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  stop_exec_i,
   input  wire logic                  reset_pin_n_i,
   input  wire logic                  wake_pin_n_i,
   input  wire sms_pkg::sms_irq_t     irq_i,
   input  wire logic                  bdc_background_i,
   input  wire logic                  bdc_mem_status_i,
   input  wire sms_pkg::sms_axi_m2s_t axi_i,
   output sms_pkg::sms_axi_s2m_t      axi_o,
   output logic [1:0]                 stop_mode_o,
   output logic                       bus_clk_en_o,
   output logic                       cpu_clk_en_o,
   output logic                       periph_clk_en_o,
   output logic                       bdm_clk_en_o,
   output logic                       regulator_full_o,
   output logic                       regulator_on_o,
   output logic                       core_power_o,
   output logic                       ram_power_o,
   output logic                       adc_run_o,
   output logic                       int_ref_run_o,
   output logic                       ext_osc_run_o,
   output logic                       pin_latch_o,
   output logic                       pin_hiz_o,
   output logic                       wake_pin_mode_o,
   output logic                       wake_pin_pullup_en_o,
   output logic                       illegal_op_reset_o,
   output logic                       sys_reset_o,
   output logic                       por_reset_o,
   output logic                       irq_vector_o,
   output sms_pkg::sms_irq_t          irq_src_o,
   output logic                       bdm_enter_o,
   output logic                       bdc_mem_access_o,
   output logic                       bdc_stop_err_o,
   output logic                       partial_power_down_flag_o,
   output logic                       pdf_o
);

   sms_pkg::sms_state_t st_reg;
   sms_pkg::sms_state_t st_next;
   logic                aw_rdy;
   logic                w_rdy;
   logic                ar_rdy;
   logic                ack_wr;
   logic                lvd_stop;

   // stop level from the bits as they stand right now
   function automatic sms_pkg::sms_mode_t sel_mode(input sms_pkg::sms_cfg_t c);
      if (c.debug_mode_enable ||
          (c.low_volt_detect_enable && c.low_volt_detect_in_stop_enable)) begin
         sel_mode = sms_pkg::SMS_STOP3;
      end else if (!c.power_down_control) begin
         sel_mode = sms_pkg::SMS_STOP3;
      end else if (c.partial_power_down_control) begin
         sel_mode = sms_pkg::SMS_STOP2;
      end else begin
         sel_mode = sms_pkg::SMS_STOP1;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   assign aw_rdy = !st_reg.aw_got && !st_reg.bvalid;
   assign w_rdy  = !st_reg.w_got && !st_reg.bvalid;
   assign ar_rdy = !st_reg.rvalid;
   assign ack_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid &&
                   st_reg.awaddr == `SMS_OFS_STAT && st_reg.wstrb[1] &&
                   st_reg.wdata[`SMS_ACK_BIT];
   assign lvd_stop = st_reg.cfg.low_volt_detect_enable &&
                     st_reg.cfg.low_volt_detect_in_stop_enable;

   always_comb begin
      logic [31:0] cfgw;
      cfgw    = 32'h0;
      st_next = st_reg;
      st_next.rst_s1    = reset_pin_n_i;
      st_next.rst_s2    = st_reg.rst_s1;
      st_next.wk_s1     = wake_pin_n_i;
      st_next.wk_s2     = st_reg.wk_s1;
      st_next.sys_rst   = 1'b0;
      st_next.por       = 1'b0;
      st_next.irq_vec   = 1'b0;
      st_next.bdm_enter = 1'b0;
      st_next.ill_rst   = 1'b0;
      st_next.dbg_err   = 1'b0;

      // register bus: write side
      if (axi_i.awvalid && aw_rdy) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = axi_i.awaddr;
      end
      if (axi_i.wvalid && w_rdy) begin
         st_next.w_got = 1'b1;
         st_next.wdata = axi_i.wdata;
         st_next.wstrb = axi_i.wstrb;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = `SMS_RESP_OKAY;
         if (st_reg.awaddr == `SMS_OFS_CFG) begin
            cfgw = merge({18'h0, st_reg.cfg}, st_reg.wdata, st_reg.wstrb);
            st_next.cfg = cfgw[13:0];
         end else if (st_reg.awaddr != `SMS_OFS_STAT) begin
            st_next.bresp = `SMS_RESP_SLVERR;
         end
      end
      if (st_reg.bvalid && axi_i.bready) begin
         st_next.bvalid = 1'b0;
      end

      // register bus: read side
      if (axi_i.arvalid && ar_rdy) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = `SMS_RESP_OKAY;
         st_next.rdata  = 32'h0;
         if (axi_i.araddr == `SMS_OFS_CFG) begin
            st_next.rdata = {18'h0, st_reg.cfg};
         end else if (axi_i.araddr == `SMS_OFS_STAT) begin
            st_next.rdata = {27'h0, st_reg.latch_hold, st_reg.mode,
                             st_reg.deep_power_down_flag, st_reg.partial_power_down_flag};
         end else begin
            st_next.rresp = `SMS_RESP_SLVERR;
         end
      end else if (st_reg.rvalid && axi_i.rready) begin
         st_next.rvalid = 1'b0;
      end

      // acknowledge opens latches and clears flags
      if (ack_wr) begin
         st_next.partial_power_down_flag       = 1'b0;
         st_next.deep_power_down_flag        = 1'b0;
         st_next.latch_hold = 1'b0;
      end

      // debug status commands never touch memory while stopped
      if (bdc_mem_status_i && st_reg.mode != sms_pkg::SMS_RUN) begin
         st_next.dbg_err = 1'b1;
      end

      unique case (st_reg.mode)
         sms_pkg::SMS_RUN: begin
            if (stop_exec_i) begin
               if (!st_reg.cfg.stop_enable_bit) begin
                  st_next.ill_rst = 1'b1;
               end else begin
                  // bits frozen here; later writes cannot move the level
                  st_next.mode      = sel_mode(st_reg.cfg);
                  st_next.bdm_stop  = st_reg.cfg.debug_mode_enable;
                  st_next.vreg_stop = lvd_stop;
                  if (sel_mode(st_reg.cfg) == sms_pkg::SMS_STOP2) begin
                     st_next.latch_hold = 1'b1;
                  end
               end
            end
         end
         sms_pkg::SMS_STOP3: begin
            if (!st_reg.rst_s2) begin
               st_next.mode    = sms_pkg::SMS_RUN;
               st_next.sys_rst = 1'b1;
            end else if (bdc_background_i && st_reg.bdm_stop) begin
               st_next.mode      = sms_pkg::SMS_RUN;
               st_next.bdm_enter = 1'b1;
            end else if (|irq_i) begin
               st_next.mode    = sms_pkg::SMS_RUN;
               st_next.irq_vec = 1'b1;
               st_next.irq_src = irq_i;
            end
         end
         sms_pkg::SMS_STOP2,
         sms_pkg::SMS_STOP1: begin
            if (!st_reg.wk_s2 || (irq_i.periodic_wake_interrupt && st_reg.cfg.rti_wake_en)) begin
               st_next.mode = sms_pkg::SMS_RUN;
               st_next.por  = 1'b1;
               st_next.cfg  = `SMS_CFG_RST;
               // set wins over a same-cycle acknowledge
               if (st_reg.mode == sms_pkg::SMS_STOP2) begin
                  st_next.partial_power_down_flag       = 1'b1;
                  st_next.latch_hold = 1'b1;
               end else begin
                  st_next.deep_power_down_flag = 1'b1;
               end
            end
         end
      endcase

      if (!rst_n_i) begin
         st_next = '0;
         st_next.cfg = `SMS_CFG_RST;
         st_next.rst_s1 = 1'b1;
         st_next.rst_s2 = 1'b1;
         st_next.wk_s1 = 1'b1;
         st_next.wk_s2 = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      st_reg <= st_next;
   end

   // one process drives the whole response struct, so it has a single driver
   always_comb begin
      axi_o.awready = aw_rdy;
      axi_o.wready  = w_rdy;
      axi_o.bvalid  = st_reg.bvalid;
      axi_o.bresp   = st_reg.bresp;
      axi_o.arready = ar_rdy;
      axi_o.rvalid  = st_reg.rvalid;
      axi_o.rdata   = st_reg.rdata;
      axi_o.rresp   = st_reg.rresp;
   end

   logic run;
   logic s3;
   assign run = st_reg.mode == sms_pkg::SMS_RUN;
   assign s3  = st_reg.mode == sms_pkg::SMS_STOP3;

   assign stop_mode_o      = st_reg.mode;
   assign bus_clk_en_o     = run;
   assign cpu_clk_en_o     = run;
   assign periph_clk_en_o  = run;
   assign bdm_clk_en_o     = run || (s3 && st_reg.bdm_stop);
   assign regulator_full_o = run || (s3 && (st_reg.bdm_stop || st_reg.vreg_stop));
   assign regulator_on_o   = st_reg.mode != sms_pkg::SMS_STOP1;
   assign core_power_o     = run || s3;
   assign ram_power_o      = st_reg.mode != sms_pkg::SMS_STOP1;
   assign adc_run_o        = run || (s3 && st_reg.cfg.adc_async_clk && lvd_stop);
   assign int_ref_run_o    = run || (s3 && st_reg.cfg.internal_ref_clock_enable &&
                                     st_reg.cfg.internal_ref_stop_enable);
   assign ext_osc_run_o    = run || (s3 && st_reg.cfg.external_ref_clock_enable &&
                                     st_reg.cfg.external_ref_stop_enable &&
                                     (!st_reg.cfg.osc_range_hi || lvd_stop));
   // pins hold from stop2 entry until the acknowledge write
   assign pin_latch_o      = st_reg.latch_hold;
   assign pin_hiz_o        = st_reg.mode == sms_pkg::SMS_STOP1;
   assign wake_pin_mode_o  = !run && !s3;
   // pullup only from software, never forced by stop entry
   assign wake_pin_pullup_en_o = st_reg.cfg.wake_pin_pullup_enable;
   assign illegal_op_reset_o = st_reg.ill_rst;
   assign sys_reset_o      = st_reg.sys_rst;
   assign por_reset_o      = st_reg.por;
   assign irq_vector_o     = st_reg.irq_vec;
   assign irq_src_o        = st_reg.irq_src;
   assign bdm_enter_o      = st_reg.bdm_enter;
   assign bdc_mem_access_o = bdc_mem_status_i && run;
   assign bdc_stop_err_o   = st_reg.dbg_err;
   assign partial_power_down_flag_o           = st_reg.partial_power_down_flag;
   assign pdf_o            = st_reg.deep_power_down_flag;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   logic go;
   assign go = run && stop_exec_i && st_reg.cfg.stop_enable_bit;

   property p_ill;
      run && stop_exec_i && !st_reg.cfg.stop_enable_bit |=> illegal_op_reset_o && run;
   endproperty
   a_ill: assert property (p_ill) else $error("no illegal reset");

   property p_bdm;
      go && st_reg.cfg.debug_mode_enable |=> s3 && bdm_clk_en_o && regulator_full_o;
   endproperty
   a_bdm: assert property (p_bdm) else $error("debug stop wrong");

   property p_lvl;
      go |=> stop_mode_o == $past(sel_mode(st_reg.cfg));
   endproperty
   a_lvl: assert property (p_lvl) else $error("wrong stop level");

   property p_s2;
      go && sel_mode(st_reg.cfg) == sms_pkg::SMS_STOP2 |=> pin_latch_o && ram_power_o;
   endproperty
   a_s2: assert property (p_s2) else $error("stop2 pins not held");

   property p_s1;
      go && sel_mode(st_reg.cfg) == sms_pkg::SMS_STOP1 |=> pin_hiz_o && !ram_power_o;
   endproperty
   a_s1: assert property (p_s1) else $error("stop1 pins not released");

   property p_clk;
      !run |-> !bus_clk_en_o && !cpu_clk_en_o && !periph_clk_en_o;
   endproperty
   a_clk: assert property (p_clk) else $error("clock running in stop");

   property p_hold;
      !run |=> run || $stable(stop_mode_o);
   endproperty
   a_hold: assert property (p_hold) else $error("level moved in stop");

   property p_partial_power_down_flag;
      partial_power_down_flag_o && !ack_wr |=> partial_power_down_flag_o && pin_latch_o;
   endproperty
   a_partial_power_down_flag: assert property (p_partial_power_down_flag) else $error("flag lost early");

   property p_dbg;
      bdc_mem_status_i && !run |-> !bdc_mem_access_o ##1 bdc_stop_err_o;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug access in stop");

   property p_s3_rst;
      s3 && !st_reg.rst_s2 |=> run && sys_reset_o;
   endproperty
   a_s3_rst: assert property (p_s3_rst) else $error("reset pin exit missed");

   property p_bg;
      s3 && st_reg.rst_s2 && bdc_background_i && st_reg.bdm_stop |=> run && bdm_enter_o;
   endproperty
   a_bg: assert property (p_bg) else $error("background wake missed");

   property p_s3keep;
      s3 |-> core_power_o && ram_power_o && !pin_hiz_o;
   endproperty
   a_s3keep: assert property (p_s3keep) else $error("stop3 state lost");

   property p_osc;
      s3 && st_reg.cfg.osc_range_hi && !lvd_stop |-> !ext_osc_run_o;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator left running");

   property p_wake;
      !run && !s3 && !st_reg.wk_s2 |=> run && por_reset_o && st_reg.cfg == `SMS_CFG_RST;
   endproperty
   a_wake: assert property (p_wake) else $error("wake pin exit wrong");

   property p_rti;
      !run && !s3 && irq_i.periodic_wake_interrupt && st_reg.cfg.rti_wake_en |=> run && por_reset_o;
   endproperty
   a_rti: assert property (p_rti) else $error("periodic wake missed");

   property p_s2f;
      stop_mode_o == sms_pkg::SMS_STOP2 && !st_reg.wk_s2 |=> partial_power_down_flag_o && pin_latch_o;
   endproperty
   a_s2f: assert property (p_s2f) else $error("stop2 flag not set");

   property p_s1f;
      stop_mode_o == sms_pkg::SMS_STOP1 &&
      (!st_reg.wk_s2 || (irq_i.periodic_wake_interrupt && st_reg.cfg.rti_wake_en)) |=> pdf_o;
   endproperty
   a_s1f: assert property (p_s1f) else $error("stop1 flag not set");

   c_s3_irq: cover property (s3 ##1 irq_vector_o);
   c_s3_bdm: cover property (s3 ##1 bdm_enter_o);
   c_ill: cover property (illegal_op_reset_o);
   c_s2_ack: cover property (partial_power_down_flag_o ##[1:50] !partial_power_down_flag_o);
   c_s1_por: cover property (stop_mode_o == sms_pkg::SMS_STOP1 ##1 por_reset_o);

endmodule // sms_stop_sequencer
